// File: cgsb_config_bytes.sv
// Purpose: Config register bytes 7 to 14 of the clock generator control bank
// Assumes: Protocol engine presents one byte access per cycle, synchronous to clk_sys
// Notes:   Divider fields load from the strap-indexed table one cycle after reset release
//          Dividers reach the PLL one edge after their source bytes change
`timescale 1ns/1ns
module cgsb_config_bytes #(
  parameter logic [3:0] REVISION_CODE = 4'h5,  // Arbitrary value
  parameter logic [3:0] MAKER_CODE    = 4'ha,  // Arbitrary value
  parameter int         STRAP_WIDTH   = 3      // Width of the frequency strap
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  // Byte access from the protocol engine
  input  wire cgsb_pkg::cgsb_req_type  req,
  input  wire logic [STRAP_WIDTH-1:0]  fs_strap,
  // Read answer
  output logic [7:0]                   rdata,
  output logic                         rdata_valid,
  // Register contents
  output logic [7:0]                   readback_len,
  output logic                         third_ref_drive_sel,
  output logic                         usb_clk1_drive_sel,
  output logic                         usb_clk0_drive_sel,
  output logic [3:0]                   gfx_clk_freq_sel,
  output logic                         mn_prog_enable,
  output logic                         second_ref_drive_sel,
  output logic                         first_ref_drive_sel,
  // Effective dividers and derived frequency
  output logic [9:0]                   cpu_fb_div,
  output logic [5:0]                   cpu_ref_div,
  output logic [23:0]                  vco_freq_khz,
  output logic [14:0]                  spread_code,
  output logic                         div_loaded
);
  import cgsb_pkg::*;

  // Table index width is fixed by the table depth
  // Wider strap widths would index past the eight-entry table
  generate
    if (STRAP_WIDTH != 3) begin : g_bad_strap
      $error("STRAP_WIDTH must be 3");
    end
  endgenerate

  // Divider state: the programmed copy tracks bytes 11 and 12, the power-up
  // copy keeps the strap-table entry so clearing the enable falls back to it
  logic [9:0]  fb_div_prog;    // Feedback divider as programmed
  logic [5:0]  ref_div_prog;   // Reference divider as programmed
  logic [9:0]  fb_div_pwrup;   // Feedback divider from power-up table
  logic [5:0]  ref_div_pwrup;  // Reference divider from power-up table
  logic        load_pending;   // Table load still owed after reset
  logic [15:0] rom_word;       // Table entry picked by the strap
  logic [23:0] vco_numer;      // Reference times (N + 8)
  logic [6:0]  vco_denom;      // M + 2
  logic        wr_ok;          // Write accepted this cycle

  // Table lookup, write qualifier and VCO arithmetic
  // Writes in the load cycle are dropped so the table load cannot be torn
  // Numerator stays in 24 bits: 14318 x (1023 + 8) still fits
  assign rom_word  = CGSB_DIV_ROM[fs_strap];
  assign wr_ok     = req.wr && !load_pending;
  assign vco_numer = 24'(CGSB_REF_CLK_KHZ * (24'(fb_div_prog) + CGSB_FB_OFFSET));
  assign vco_denom = 7'(ref_div_prog) + CGSB_REF_OFFSET;

  // Read-back length register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Nine bytes returned after power-up
      readback_len <= CGSB_RST_READBACK;
    end else if (wr_ok && req.addr == CGSB_OFS_READBACK) begin
      // Every bit is writable; this byte has no reserved bits
      readback_len <= req.wdata;
    end
  end

  // Byte 9: output strengths and graphics frequency select
  // Drive strength: 0 selects single, 1 selects double
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // All three outputs start at double strength
      third_ref_drive_sel <= CGSB_RST_DRIVE;
      usb_clk1_drive_sel  <= CGSB_RST_DRIVE;
      usb_clk0_drive_sel  <= CGSB_RST_DRIVE;
      gfx_clk_freq_sel    <= CGSB_RST_GFX_SEL;
    end else if (wr_ok && req.addr == CGSB_OFS_DRIVE_GFX) begin
      // Bit 4 is reserved and never stored
      third_ref_drive_sel <= req.wdata[CGSB_POS_THIRD_REF];
      usb_clk1_drive_sel  <= req.wdata[CGSB_POS_USB1];
      usb_clk0_drive_sel  <= req.wdata[CGSB_POS_USB0];
      gfx_clk_freq_sel    <= req.wdata[CGSB_POS_GFX_LSB +: 4];
    end
  end

  // Byte 10: divider programming enable and reference strengths
  // The enable only steers which divider set leaves the block
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Programming disabled, both references at double strength
      mn_prog_enable       <= CGSB_RST_MN_EN;
      second_ref_drive_sel <= CGSB_RST_DRIVE;
      first_ref_drive_sel  <= CGSB_RST_DRIVE;
    end else if (wr_ok && req.addr == CGSB_OFS_MN_REF) begin
      // Bits 4:0 are reserved and never stored
      mn_prog_enable       <= req.wdata[CGSB_POS_MN_EN];
      second_ref_drive_sel <= req.wdata[CGSB_POS_SECOND_REF];
      first_ref_drive_sel  <= req.wdata[CGSB_POS_FIRST_REF];
    end
  end

  // Divider fields: table load once after reset, then software writes
  // The power-up copy is written only here, so later writes never touch it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Zero until the strap-table entry is loaded
      load_pending  <= 1'h1;
      fb_div_prog   <= 10'h000;
      ref_div_prog  <= 6'h00;
      fb_div_pwrup  <= 10'h000;
      ref_div_pwrup <= 6'h00;
    end else if (load_pending) begin
      // Strap sampled after release, never under reset
      load_pending  <= 1'h0;
      fb_div_prog   <= rom_word[15:6];
      ref_div_prog  <= rom_word[5:0];
      fb_div_pwrup  <= rom_word[15:6];
      ref_div_pwrup <= rom_word[5:0];
    end else if (wr_ok && req.addr == CGSB_OFS_DIV_UPPER) begin
      // Byte 11: bit 7 is N[8], bit 6 is N[9], bits 5:0 are M
      fb_div_prog[8] <= req.wdata[CGSB_POS_FB_BIT8];
      fb_div_prog[9] <= req.wdata[CGSB_POS_FB_BIT9];
      ref_div_prog   <= req.wdata[CGSB_POS_REFDIV_LSB +: 6];
    end else if (wr_ok && req.addr == CGSB_OFS_FB_LOW) begin
      // Byte 12: low eight bits of N
      fb_div_prog[7:0] <= req.wdata;
    end
  end

  // Spread code, low byte and upper seven bits
  // The two bytes are written independently, with no shadow copy
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // No spread programmed after reset
      spread_code <= CGSB_RST_SPREAD;
    end else if (wr_ok && req.addr == CGSB_OFS_SPREAD_LOW) begin
      // Byte 13: code bits 7:0
      spread_code[7:0] <= req.wdata;
    end else if (wr_ok && req.addr == CGSB_OFS_SPREAD_HI) begin
      // Byte 14: bit 7 reserved, bits 6:0 are code bits 14:8
      spread_code[14:8] <= req.wdata[6:0];
    end
  end

  // Dividers handed to the PLL: programmed only while enabled
  // One register stage, so the PLL sees a change one edge after its source
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Nothing reaches the PLL before the table load
      cpu_fb_div  <= 10'h000;
      cpu_ref_div <= 6'h00;
      div_loaded  <= 1'h0;
    end else begin
      // Enable picks the programmed set, otherwise the strap-table entry
      cpu_fb_div  <= mn_prog_enable ? fb_div_prog : fb_div_pwrup;
      cpu_ref_div <= mn_prog_enable ? ref_div_prog : ref_div_pwrup;
      div_loaded  <= !load_pending;
    end
  end

  // VCO frequency from the values held in bytes 11 and 12
  // Follows the byte contents whether or not programming is enabled
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Zero only under reset; the load cycle still divides the zeroed dividers
      vco_freq_khz <= 24'h000000;
    end else begin
      // Floor division; the denominator is never below two
      vco_freq_khz <= 24'(vco_numer / {17'h00000, vco_denom});
    end
  end

  // Read data: one cycle after the read request
  // A read and a write in one cycle return the old value
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // No answer pending after reset
      rdata       <= 8'h00;
      rdata_valid <= 1'h0;
    end else begin
      // Valid follows every read request by exactly one edge
      rdata_valid <= req.rd;
      if (req.rd) begin
        // Data holds between reads so a late sampler still sees it
        case (req.addr)
          // Identity byte is a constant; writes never reach it
          CGSB_OFS_IDENT:      rdata <= {REVISION_CODE, MAKER_CODE};
          CGSB_OFS_READBACK:   rdata <= readback_len;
          CGSB_OFS_DRIVE_GFX:  rdata <= {third_ref_drive_sel, usb_clk1_drive_sel, usb_clk0_drive_sel,
                                         1'h0, gfx_clk_freq_sel};
          CGSB_OFS_MN_REF:     rdata <= {mn_prog_enable, second_ref_drive_sel, first_ref_drive_sel,
                                         5'h00};
          // Byte 11 packs N[8] above N[9], as it is written
          CGSB_OFS_DIV_UPPER:  rdata <= {fb_div_prog[8], fb_div_prog[9], ref_div_prog};
          CGSB_OFS_FB_LOW:     rdata <= fb_div_prog[7:0];
          CGSB_OFS_SPREAD_LOW: rdata <= spread_code[7:0];
          CGSB_OFS_SPREAD_HI:  rdata <= {1'h0, spread_code[14:8]};
          default:             rdata <= 8'h00;  // Unmapped bytes read zero
        endcase
      end
    end
  end

endmodule

// File: cgsb_pkg.sv
// Purpose: Shared constants and types for the clock generator config bytes 7 to 14
// Assumes: Byte-wide register access from an SMBus protocol engine
// Notes:   Offsets are byte addresses as seen by the protocol engine
package cgsb_pkg;

  // Register byte offsets
  localparam logic [7:0] CGSB_OFS_IDENT      = 8'h07;
  localparam logic [7:0] CGSB_OFS_READBACK   = 8'h08;
  localparam logic [7:0] CGSB_OFS_DRIVE_GFX  = 8'h09;
  localparam logic [7:0] CGSB_OFS_MN_REF     = 8'h0a;
  localparam logic [7:0] CGSB_OFS_DIV_UPPER  = 8'h0b;
  localparam logic [7:0] CGSB_OFS_FB_LOW     = 8'h0c;
  localparam logic [7:0] CGSB_OFS_SPREAD_LOW = 8'h0d;
  localparam logic [7:0] CGSB_OFS_SPREAD_HI  = 8'h0e;

  // Field positions
  localparam int CGSB_POS_REV_LSB    = 4;
  localparam int CGSB_POS_THIRD_REF  = 7;
  localparam int CGSB_POS_USB1       = 6;
  localparam int CGSB_POS_USB0       = 5;
  localparam int CGSB_POS_GFX_LSB    = 0;
  localparam int CGSB_POS_MN_EN      = 7;
  localparam int CGSB_POS_SECOND_REF = 6;
  localparam int CGSB_POS_FIRST_REF  = 5;
  localparam int CGSB_POS_FB_BIT8    = 7;
  localparam int CGSB_POS_FB_BIT9    = 6;
  localparam int CGSB_POS_REFDIV_LSB = 0;

  // Reset values
  localparam logic [7:0]  CGSB_RST_READBACK = 8'h09;
  localparam logic        CGSB_RST_DRIVE    = 1'h1;
  localparam logic [3:0]  CGSB_RST_GFX_SEL  = 4'h0;
  localparam logic        CGSB_RST_MN_EN    = 1'h0;
  localparam logic [14:0] CGSB_RST_SPREAD   = 15'h0000;

  // VCO arithmetic: reference in kHz and divider offsets
  localparam logic [23:0] CGSB_REF_CLK_KHZ = 24'h0037ee;
  localparam logic [23:0] CGSB_FB_OFFSET   = 24'h000008;
  localparam logic [6:0]  CGSB_REF_OFFSET  = 7'h02;

  // Default divider table, {feedback[9:0], reference[5:0]}, indexed by strap
  localparam logic [15:0] CGSB_DIV_ROM [0:7] = '{
    16'h3004, 16'h3204, 16'h3404, 16'h3604,
    16'h3804, 16'h3a04, 16'h3c04, 16'h3e04
  };

  // Register access request from the protocol engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cgsb_req_type;

endpackage

// File: cgsb_host_model.sv
// Purpose: Host side model issuing single byte accesses to the config bytes
// Assumes: Requests launch just after a rising edge and last one cycle
// Notes:   Read answer is sampled once the next edge has settled
`timescale 1ns/1ns
module cgsb_host_model
  import cgsb_pkg::*;
(
  input  wire logic              clk_sys,
  output cgsb_pkg::cgsb_req_type req,
  input  wire logic [7:0]        rdata,
  input  wire logic              rdata_valid
);
  // Idle bus from time zero
  initial req = '0;
  // One write pulse; the lowering edge keeps two calls apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) req <= {2'b10, a, d};
    @(posedge clk_sys) req <= '0;
  endtask
  // One read pulse; data and valid taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    @(posedge clk_sys) req <= {2'b01, a, 8'h00};
    @(posedge clk_sys) req <= '0;
    #1;
    ok = rdata_valid;
    d = rdata;
  endtask
endmodule

// File: cgsb_config_properties.sv
// Purpose: Port assertions for the config byte bank
// Assumes: Default revision and maker codes, so byte 7 reads 0x5a
// Notes:   Writes count only once the divider load is done
`timescale 1ns/1ns
module cgsb_config_properties
  import cgsb_pkg::*;
(
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire cgsb_pkg::cgsb_req_type req,
  input wire logic [7:0]             rdata,
  input wire logic                   rdata_valid,
  input wire logic [7:0]             readback_len,
  input wire logic [3:0]             gfx_clk_freq_sel,
  input wire logic                   mn_prog_enable,
  input wire logic                   first_ref_drive_sel,
  input wire logic [9:0]             cpu_fb_div,
  input wire logic [5:0]             cpu_ref_div,
  input wire logic [14:0]            spread_code,
  input wire logic                   div_loaded
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Accepted write to one byte offset
  sequence wr_at(logic [7:0] a);
    div_loaded && req.wr && req.addr == a;
  endsequence
  // Lone read request
  sequence lone_rd;
    req.rd ##1 !req.rd;
  endsequence
  rd_pulse_a: assert property (lone_rd |-> rdata_valid ##1 !rdata_valid)
    else $error("read answer pulse wrong");
  ident_ro_a: assert property (req.rd && req.addr == CGSB_OFS_IDENT |=> rdata == 8'h5a)
    else $error("identity byte wrong");
  len_wr_a: assert property (wr_at(CGSB_OFS_READBACK) |=> readback_len == $past(req.wdata))
    else $error("readback length not written");
  gfx_wr_a: assert property (wr_at(CGSB_OFS_DRIVE_GFX) |=> gfx_clk_freq_sel == $past(req.wdata[3:0]))
    else $error("graphics select not written");
  mn_wr_a: assert property (wr_at(CGSB_OFS_MN_REF) |=>
    {mn_prog_enable, first_ref_drive_sel} == {$past(req.wdata[7]), $past(req.wdata[5])})
    else $error("enable or strength not written");
  div_gate_a: assert property (wr_at(CGSB_OFS_DIV_UPPER) ##1 (mn_prog_enable && !req.wr) |=>
    cpu_ref_div == $past(req.wdata[5:0], 2) && cpu_fb_div[9:8] == {$past(req.wdata[6], 2), $past(req.wdata[7], 2)})
    else $error("programmed dividers not applied");
  div_hold_a: assert property (div_loaded && !mn_prog_enable ##1 !mn_prog_enable |=>
    $stable(cpu_fb_div) && $stable(cpu_ref_div))
    else $error("dividers moved while disabled");
  spread_hi_a: assert property (wr_at(CGSB_OFS_SPREAD_HI) |=> spread_code[14:8] == $past(req.wdata[6:0]))
    else $error("spread high bits not written");
endmodule
bind cgsb_config_bytes cgsb_config_properties chk_u (.clk_sys, .rst_n, .req, .rdata, .rdata_valid, .readback_len,
  .gfx_clk_freq_sel, .mn_prog_enable, .first_ref_drive_sel, .cpu_fb_div, .cpu_ref_div, .spread_code, .div_loaded);

// File: tb_top.sv
// Purpose: Self-checking bench for the config byte bank
// Assumes: Strap 5 selects fb 0x0e8, ref 4; strap 2 on reload selects fb 0x0d0, ref 4
// Notes:   Vco figures are worked out here from the kHz rule
`timescale 1ns/1ns
module tb_top;
  import cgsb_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst_n, rdata_valid, third, usb1, usb0, mn_en, second, first, div_loaded;
  cgsb_req_type req;
  logic [2:0]   fs_strap;
  logic [7:0]   rdata, readback_len;
  logic [3:0]   gfx;
  logic [9:0]   cpu_fb_div;
  logic [5:0]   cpu_ref_div;
  logic [23:0]  vco;
  logic [14:0]  spread_code;
  int           errors, compares;
  always #4 clk_sys = ~clk_sys;
  cgsb_config_bytes dut_u (.clk_sys, .rst_n, .req, .fs_strap, .rdata, .rdata_valid, .readback_len,
    .third_ref_drive_sel(third), .usb_clk1_drive_sel(usb1), .usb_clk0_drive_sel(usb0), .gfx_clk_freq_sel(gfx),
    .mn_prog_enable(mn_en), .second_ref_drive_sel(second), .first_ref_drive_sel(first), .cpu_fb_div,
    .cpu_ref_div, .vco_freq_khz(vco), .spread_code, .div_loaded);
  cgsb_host_model host_u (.clk_sys, .req, .rdata, .rdata_valid);
  // Compare with a running count; values up to 40 bits
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Read through the host, valid flag checked with the data
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    host_u.rd(a, d, ok);
    chk({ok, d}, {1'b1, exp});
  endtask
  // Let a write land and the dividers follow it
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Power-up values and the strap table load
  task automatic t_reset();
    settle();
    chk(readback_len, 8'h09);
    chk({third, usb1, usb0, gfx, mn_en, second, first}, 10'h383);
    chk({cpu_fb_div, cpu_ref_div, spread_code}, {16'h3a04, 15'h0000});
    chk({div_loaded, vco}, {1'b1, 24'(14318 * 240 / 6)});
    $display("reset test done");
  endtask
  // Identity, reserved bits and plain fields
  task automatic t_fields();
    host_u.wr(CGSB_OFS_IDENT, 8'hff);
    rd_chk(CGSB_OFS_IDENT, 8'h5a);
    rd_chk(8'h20, 8'h00);
    host_u.wr(CGSB_OFS_READBACK, 8'ha5);
    rd_chk(CGSB_OFS_READBACK, 8'ha5);
    host_u.wr(CGSB_OFS_DRIVE_GFX, 8'h5f);
    rd_chk(CGSB_OFS_DRIVE_GFX, 8'h4f);
    chk({third, usb1, usb0, gfx}, 7'h2f);
    host_u.wr(CGSB_OFS_MN_REF, 8'h5f);
    rd_chk(CGSB_OFS_MN_REF, 8'h40);
    host_u.wr(CGSB_OFS_SPREAD_LOW, 8'h3c);
    host_u.wr(CGSB_OFS_SPREAD_HI, 8'hff);
    rd_chk(CGSB_OFS_SPREAD_HI, 8'h7f);
    chk(spread_code, 15'h7f3c);
    rd_chk(CGSB_OFS_SPREAD_LOW, 8'h3c);
    $display("field test done");
  endtask
  // Divider programming gated by the enable
  task automatic t_divider();
    host_u.wr(CGSB_OFS_DIV_UPPER, 8'h6d);
    host_u.wr(CGSB_OFS_FB_LOW, 8'haa);
    rd_chk(CGSB_OFS_DIV_UPPER, 8'h6d);
    rd_chk(CGSB_OFS_FB_LOW, 8'haa);
    settle();
    chk({cpu_fb_div, cpu_ref_div, vco}, {16'h3a04, 24'(14318 * 690 / 47)});
    host_u.wr(CGSB_OFS_MN_REF, 8'h80);
    settle();
    chk({cpu_fb_div, cpu_ref_div}, {10'h2aa, 6'h2d});
    host_u.wr(CGSB_OFS_DIV_UPPER, 8'h81);
    settle();
    chk({cpu_fb_div, cpu_ref_div, vco}, {16'h6a81, 24'(14318 * 434 / 3)});
    $display("divider test done");
  endtask
  // Mid-run reset with a new strap; a write in the load cycle is dropped
  task automatic t_reload();
    @(posedge clk_sys);
    rst_n    <= 1'b0;
    fs_strap <= 3'h2;
    repeat (2) @(posedge clk_sys);
    fork
      host_u.wr(CGSB_OFS_READBACK, 8'h33);
      @(posedge clk_sys) rst_n <= 1'b1;
    join
    settle();
    chk({readback_len, div_loaded, spread_code}, {8'h09, 1'b1, 15'h0000});
    chk({third, usb1, usb0, gfx, mn_en, second, first}, 10'h383);
    chk({cpu_fb_div, cpu_ref_div, vco}, {16'h3404, 24'(14318 * 216 / 6)});
    $display("reload test done");
  endtask
  // Counts, verdict and stop
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n = 1'b0;
    fs_strap = 3'h5;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_divider();
    t_reload();
    end_of_test();
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    end_of_test();
  end
endmodule
